/* icgl_defines.svh */
// Offsets, field positions, reset values and codes of the clock generator loop
`ifndef ICGL_DEFINES_SVH
`define ICGL_DEFINES_SVH
`define ICGL_OFF_CTRL 8'h00
`define ICGL_OFF_MULT 8'h04
`define ICGL_OFF_STAT 8'h08
`define ICGL_OFF_WORD 8'h0c
`define ICGL_OFF_ISTAT 8'h10
`define ICGL_OFF_IEN 8'h14
`define ICGL_OFF_ICLR 8'h18
`define ICGL_OFF_CNT 8'h1c
`define ICGL_IDX_CTRL 3'h0
`define ICGL_IDX_MULT 3'h1
`define ICGL_IDX_STAT 3'h2
`define ICGL_IDX_WORD 3'h3
`define ICGL_IDX_ISTAT 3'h4
`define ICGL_IDX_IEN 3'h5
`define ICGL_IDX_ICLR 3'h6
`define ICGL_IDX_NONE 3'h7
`define ICGL_CTRL_INT_BIT 0
`define ICGL_CTRL_EXT_BIT 1
`define ICGL_CTRL_RST 2'h1
`define ICGL_MULT_RST 8'h01
`define ICGL_WORD_RST 12'h400
`define ICGL_WORD_MAX 12'h9ff
`define ICGL_WORD_TOP 12'hfff
`define ICGL_OSC_DIVIDER_FIELD_SLOW 4'h9
`define ICGL_CORR_BIG 12'h020
`define ICGL_CORR_MID 12'h008
`define ICGL_CORR_FINE 12'h001
`define ICGL_BAND_LO32 3'h0
`define ICGL_BAND_LO8 3'h1
`define ICGL_BAND_LO1 3'h2
`define ICGL_BAND_HI1 3'h3
`define ICGL_BAND_HI8 3'h4
`define ICGL_BAND_HI32 3'h5
`define ICGL_IRQ_W 3
`define ICGL_IRQ_LOCK 0
`define ICGL_IRQ_UNLOCK 1
`define ICGL_IRQ_LIMIT 2
`endif

/* icgl_loop_filter.sv */
// Digital loop filter stepping the oscillator control word
`timescale 1ns/10ps
`include "icgl_defines.svh"
module icgl_loop_filter (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic done_i,
  input wire icgl_pkg::icgl_band_t band_i,
  input wire logic load_i,
  input wire icgl_pkg::icgl_word_t load_val_i,
  output icgl_pkg::icgl_word_t word_o,
  output icgl_pkg::icgl_word_t eff_o,
  output logic stable_o
);
  import icgl_pkg::*;
  icgl_lf_st_t st_ff, nxt_st;
  icgl_word_t corr;
  logic [12:0] sum;

  assign corr = band_corr(band_i);
  assign sum = {1'b0, st_ff.word} + {1'b0, corr};

  always_comb begin
    nxt_st = st_ff;
    if (load_i) begin
      nxt_st.word = load_val_i;
    end else if (en_i && done_i) begin
      // Wrap past the top would jump to the fastest word, so clamp
      if (!corr[11] && sum[12]) begin
        nxt_st.word = `ICGL_WORD_TOP;
      end else begin
        nxt_st.word = sum[11:0];
      end
      nxt_st.stable = band_near(band_i);
    end else if (!en_i) begin
      nxt_st.stable = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
      st_ff.word <= `ICGL_WORD_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign word_o = st_ff.word;
  // Divider codes above the slowest act as the slowest
  assign eff_o = {(st_ff.word[11:8] > `ICGL_OSC_DIVIDER_FIELD_SLOW) ? `ICGL_OSC_DIVIDER_FIELD_SLOW : st_ff.word[11:8], st_ff.word[7:0]};
  assign stable_o = st_ff.stable;
endmodule

/* icgl_mod_div.sv */
// Modulo-N divider making the base clock from the sampled oscillator
`timescale 1ns/10ps
module icgl_mod_div #(
  parameter int N_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic osc_i,
  input wire logic [N_W-1:0] n_i,
  output logic base_o
);
  import icgl_pkg::*;
  typedef struct packed {
    logic [N_W-1:0] cnt;
    logic base;
    logic osc_q;
  } icgl_div_st_t;
  icgl_div_st_t st_ff, nxt_st;
  logic rise;

  assign rise = osc_i & ~st_ff.osc_q;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.osc_q = osc_i;
    if (!en_i) begin
      nxt_st.cnt = '0;
      nxt_st.base = 1'b0;
    end else if (n_i <= N_W'(1)) begin
      nxt_st.cnt = '0;
      nxt_st.base = osc_i;
    end else if (rise) begin
      if (st_ff.cnt >= N_W'(n_i - 1'b1)) begin
        nxt_st.cnt = '0;
      end else begin
        nxt_st.cnt = N_W'(st_ff.cnt + 1'b1);
      end
      nxt_st.base = nxt_st.cnt < (n_i >> 1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign base_o = st_ff.base;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_cnt_in_range: assert property (en_i && n_i > N_W'(1) && $stable(n_i) |-> st_ff.cnt < n_i)
    else $error("divider count left its range");
endmodule

/* icgl_pkg.sv */
// Types and band decoding of the clock generator loop
`include "icgl_defines.svh"
package icgl_pkg;
  typedef logic [2:0] icgl_band_t;
  typedef logic [11:0] icgl_word_t;
  typedef struct packed {
    logic stop;
    logic [1:0] ctrl;
    logic [7:0] mult;
    logic [`ICGL_IRQ_W-1:0] ien;
    logic [`ICGL_IRQ_W-1:0] ista;
    logic osc_q;
    logic ext_q;
    logic stable_q;
    logic oor_q;
    logic [15:0] corr_cnt;
    logic [31:0] prdata;
  } icgl_top_st_t;
  typedef struct packed {
    icgl_word_t word;
    logic stable;
  } icgl_lf_st_t;

  function automatic icgl_word_t band_corr(input icgl_band_t b);
    case (b)
      `ICGL_BAND_LO32: band_corr = -`ICGL_CORR_BIG;
      `ICGL_BAND_LO8: band_corr = -`ICGL_CORR_MID;
      `ICGL_BAND_LO1: band_corr = -`ICGL_CORR_FINE;
      `ICGL_BAND_HI1: band_corr = `ICGL_CORR_FINE;
      `ICGL_BAND_HI8: band_corr = `ICGL_CORR_MID;
      `ICGL_BAND_HI32: band_corr = `ICGL_CORR_BIG;
      default: band_corr = '0;
    endcase
  endfunction

  function automatic logic band_near(input icgl_band_t b);
    band_near = (b == `ICGL_BAND_LO1) || (b == `ICGL_BAND_HI1);
  endfunction
endpackage

/* icgl_top.sv */
// Clock enable, divider and loop filter of the internal clock generator
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "icgl_defines.svh"
module icgl_top (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic STOP_MODE_I,
  input wire logic OSC_RAW_I,
  input wire logic EXT_RAW_I,
  input wire logic CMP_DONE_I,
  input wire icgl_pkg::icgl_band_t CMP_BAND_I,
  output logic STOP_ALL_CLOCKS_O,
  output logic INTERNAL_GEN_ENABLE_O,
  output logic EXTERNAL_GEN_ENABLE_O,
  output logic INTERNAL_OSC_CLOCK_O,
  output logic EXTERNAL_CLOCK_O,
  output logic BASE_CLOCK_O,
  output icgl_pkg::icgl_word_t OSC_CTRL_WORD_O,
  output logic FILTER_STABLE_FLAG_O,
  output logic IRQ_O
);
  import icgl_pkg::*;

  icgl_top_st_t st_ff, nxt_st;
  logic int_en;
  logic ext_en;
  logic base_lvl;
  logic stable;
  logic wr;
  logic word_load;
  logic [2:0] idx;
  logic [`ICGL_IRQ_W-1:0] ev;
  logic [`ICGL_IRQ_W-1:0] clr;
  logic [31:0] rdata;
  icgl_word_t word_raw;
  icgl_word_t word_eff;

  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    case (a)
      `ICGL_OFF_CTRL: reg_idx = `ICGL_IDX_CTRL;
      `ICGL_OFF_MULT: reg_idx = `ICGL_IDX_MULT;
      `ICGL_OFF_STAT: reg_idx = `ICGL_IDX_STAT;
      `ICGL_OFF_WORD: reg_idx = `ICGL_IDX_WORD;
      `ICGL_OFF_ISTAT: reg_idx = `ICGL_IDX_ISTAT;
      `ICGL_OFF_IEN: reg_idx = `ICGL_IDX_IEN;
      `ICGL_OFF_ICLR: reg_idx = `ICGL_IDX_ICLR;
      default: reg_idx = `ICGL_IDX_NONE;
    endcase
  endfunction

  // Correction counter shares the last slot; decoded apart from the table
  logic cnt_sel;
  assign cnt_sel = (PADDR_I == `ICGL_OFF_CNT);
  assign idx = reg_idx(PADDR_I);
  assign wr = PSEL_I & PENABLE_I & PWRITE_I;
  assign word_load = wr && (idx == `ICGL_IDX_WORD);

  assign int_en = st_ff.ctrl[`ICGL_CTRL_INT_BIT] & ~st_ff.stop;
  assign ext_en = st_ff.ctrl[`ICGL_CTRL_EXT_BIT] & ~st_ff.stop;

  icgl_mod_div #(
    .N_W(8)
  ) u_div (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RSTN_I),
    .en_i(int_en),
    .osc_i(OSC_RAW_I),
    .n_i(st_ff.mult),
    .base_o(base_lvl)
  );

  icgl_loop_filter u_lf (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RSTN_I),
    .en_i(int_en),
    .done_i(CMP_DONE_I),
    .band_i(CMP_BAND_I),
    .load_i(word_load),
    .load_val_i(PWDATA_I[11:0]),
    .word_o(word_raw),
    .eff_o(word_eff),
    .stable_o(stable)
  );

  always_comb begin
    case (idx)
      `ICGL_IDX_CTRL: rdata = {30'h0, st_ff.ctrl};
      `ICGL_IDX_MULT: rdata = {24'h0, st_ff.mult};
      `ICGL_IDX_STAT: rdata = {28'h0, st_ff.stop, stable, ext_en, int_en};
      `ICGL_IDX_WORD: rdata = {4'h0, word_eff, 4'h0, word_raw};
      `ICGL_IDX_ISTAT: rdata = {29'h0, st_ff.ista};
      `ICGL_IDX_IEN: rdata = {29'h0, st_ff.ien};
      default: rdata = cnt_sel ? {16'h0, st_ff.corr_cnt} : 32'h0;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    ev = '0;
    clr = '0;
    nxt_st.stop = STOP_MODE_I;
    nxt_st.osc_q = OSC_RAW_I;
    nxt_st.ext_q = EXT_RAW_I;
    nxt_st.stable_q = stable;
    nxt_st.oor_q = word_raw[11:8] > `ICGL_OSC_DIVIDER_FIELD_SLOW;
    ev[`ICGL_IRQ_LOCK] = stable & ~st_ff.stable_q;
    ev[`ICGL_IRQ_UNLOCK] = ~stable & st_ff.stable_q;
    ev[`ICGL_IRQ_LIMIT] = nxt_st.oor_q & ~st_ff.oor_q;
    if (CMP_DONE_I && int_en) begin
      nxt_st.corr_cnt = 16'(st_ff.corr_cnt + 1'b1);
    end
    if (wr) begin
      case (idx)
        `ICGL_IDX_CTRL: nxt_st.ctrl = PWDATA_I[1:0];
        `ICGL_IDX_MULT: nxt_st.mult = PWDATA_I[7:0];
        `ICGL_IDX_IEN: nxt_st.ien = PWDATA_I[`ICGL_IRQ_W-1:0];
        `ICGL_IDX_ICLR: clr = PWDATA_I[`ICGL_IRQ_W-1:0];
        default: ;
      endcase
    end
    // New events win over a clear in the same cycle
    nxt_st.ista = (st_ff.ista & ~clr) | ev;
    if (PSEL_I && !PENABLE_I) begin
      nxt_st.prdata = rdata;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_ff <= '0;
      st_ff.ctrl <= `ICGL_CTRL_RST;
      st_ff.mult <= `ICGL_MULT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign STOP_ALL_CLOCKS_O = st_ff.stop;
  assign INTERNAL_GEN_ENABLE_O = int_en;
  assign EXTERNAL_GEN_ENABLE_O = ext_en;
  // Gating with the enable, not only reset of the divider, avoids a lag cycle
  assign INTERNAL_OSC_CLOCK_O = st_ff.osc_q & int_en;
  assign EXTERNAL_CLOCK_O = st_ff.ext_q & ext_en;
  assign BASE_CLOCK_O = base_lvl & int_en;
  assign OSC_CTRL_WORD_O = word_eff;
  assign FILTER_STABLE_FLAG_O = stable;
  assign IRQ_O = |(st_ff.ista & st_ff.ien);
  assign PRDATA_O = st_ff.prdata;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & (idx == `ICGL_IDX_NONE) & ~cnt_sel;

  // Helper: oscillator edges counted between base clock rises
  logic [8:0] edge_cnt;
  logic armed;
  logic [7:0] mult_q;
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      edge_cnt <= '0;
      armed <= 1'b0;
      mult_q <= '0;
    end else begin
      mult_q <= st_ff.mult;
      if (!int_en || (mult_q != st_ff.mult)) begin
        edge_cnt <= '0;
        armed <= 1'b0;
      end else if (BASE_CLOCK_O && !$past(BASE_CLOCK_O)) begin
        edge_cnt <= 9'h1;
        armed <= 1'b1;
      end else if (INTERNAL_OSC_CLOCK_O && !$past(INTERNAL_OSC_CLOCK_O)) begin
        edge_cnt <= 9'(edge_cnt + 1'b1);
      end
    end
  end

  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence s_apply;
    CMP_DONE_I && INTERNAL_GEN_ENABLE_O && !word_load;
  endsequence
  sequence s_word_moved_down32;
    ##1 word_raw == 12'($past(word_raw) - `ICGL_CORR_BIG);
  endsequence

  a_stop_entry: assert property (STOP_MODE_I |=> STOP_ALL_CLOCKS_O && !INTERNAL_GEN_ENABLE_O && !EXTERNAL_GEN_ENABLE_O)
    else $error("stop mode did not disable the generator");
  a_stop_clocks_low: assert property (STOP_ALL_CLOCKS_O |-> !INTERNAL_OSC_CLOCK_O && !EXTERNAL_CLOCK_O && !BASE_CLOCK_O)
    else $error("clock running during stop");
  a_int_enable_on: assert property (wr && idx == `ICGL_IDX_CTRL && PWDATA_I[0] && !STOP_MODE_I |=> INTERNAL_GEN_ENABLE_O)
    else $error("internal enable not raised");
  a_int_enable_off: assert property (STOP_MODE_I || (wr && idx == `ICGL_IDX_CTRL && !PWDATA_I[0]) |=> !INTERNAL_GEN_ENABLE_O)
    else $error("internal enable not dropped");
  a_int_off_low: assert property (!INTERNAL_GEN_ENABLE_O |-> !INTERNAL_OSC_CLOCK_O && !BASE_CLOCK_O)
    else $error("internal clocks high while disabled");
  a_ext_enable_on: assert property (wr && idx == `ICGL_IDX_CTRL && PWDATA_I[1] && !STOP_MODE_I |=> EXTERNAL_GEN_ENABLE_O)
    else $error("external enable not raised");
  a_ext_enable_off: assert property (STOP_MODE_I || (wr && idx == `ICGL_IDX_CTRL && !PWDATA_I[1]) |=> !EXTERNAL_GEN_ENABLE_O)
    else $error("external enable not dropped");
  a_ext_off_low: assert property (!EXTERNAL_GEN_ENABLE_O |-> !EXTERNAL_CLOCK_O)
    else $error("external clock high while disabled");
  a_ext_follows: assert property (EXTERNAL_GEN_ENABLE_O |-> EXTERNAL_CLOCK_O == $past(EXT_RAW_I))
    else $error("external clock does not follow its source");
  a_osc_follows: assert property (INTERNAL_GEN_ENABLE_O |-> INTERNAL_OSC_CLOCK_O == $past(OSC_RAW_I))
    else $error("oscillator clock does not follow its source");
  a_word_limit: assert property (OSC_CTRL_WORD_O <= `ICGL_WORD_MAX)
    else $error("control word beyond upper limit");
  a_div_ratio: assert property (INTERNAL_GEN_ENABLE_O && armed && st_ff.mult > 8'h1 && $rose(BASE_CLOCK_O)
    |-> edge_cnt == {1'b0, st_ff.mult})
    else $error("base period is not N oscillator periods");
  a_bypass_equal: assert property (INTERNAL_GEN_ENABLE_O && $past(INTERNAL_GEN_ENABLE_O) && st_ff.mult <= 8'h1
    && $past(st_ff.mult) <= 8'h1 |-> BASE_CLOCK_O == INTERNAL_OSC_CLOCK_O)
    else $error("bypassed base clock differs from oscillator");
  a_step_down32: assert property (s_apply and CMP_BAND_I == `ICGL_BAND_LO32 |-> s_word_moved_down32)
    else $error("largest down step wrong");
  a_step_by_band: assert property (s_apply and CMP_BAND_I == `ICGL_BAND_HI8 && word_raw < 12'hff8
    |=> word_raw == 12'($past(word_raw) + `ICGL_CORR_MID))
    else $error("mid up step wrong");
  a_stage_carry: assert property (s_apply and CMP_BAND_I == `ICGL_BAND_HI1 && word_raw[7:0] == 8'hff
    && word_raw[11:8] != 4'hf
    |=> word_raw[11:8] == 4'($past(word_raw[11:8]) + 1'b1) && word_raw[7:0] == 8'h00)
    else $error("stage carry lost");
  a_osc_divider_field_slowest: assert property (word_raw[11:8] > `ICGL_OSC_DIVIDER_FIELD_SLOW |-> OSC_CTRL_WORD_O[11:8] == `ICGL_OSC_DIVIDER_FIELD_SLOW)
    else $error("high divider code not treated as slowest");
  a_stable_set: assert property (s_apply and band_near(CMP_BAND_I) |=> FILTER_STABLE_FLAG_O)
    else $error("stable flag not set");
  a_stable_clear: assert property (s_apply and !band_near(CMP_BAND_I) |=> !FILTER_STABLE_FLAG_O)
    else $error("stable flag set with large error");
  a_word_hold: assert property (!CMP_DONE_I && !word_load |=> $stable(word_raw))
    else $error("word changed without a comparison");
endmodule

/* icgl_top_bench.sv */
// Self-checking bench for the internal clock generator loop
`timescale 1ns/10ps
`include "icgl_defines.svh"
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected %s expected %h seen %h", what, exp, got); end end
module icgl_top_bench;
  import icgl_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, stop, osc, ext, done, osc_run;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, stop_all, int_en, ext_en, int_clk, ext_clk, base, stable, irq, er;
  icgl_band_t band;
  icgl_word_t word;
  int err_count, cmp_count;
  icgl_top icgl_top_i (.SYS_CLK_I(clk), .RSTN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .STOP_MODE_I(stop), .OSC_RAW_I(osc), .EXT_RAW_I(ext), .CMP_DONE_I(done),
    .CMP_BAND_I(band), .STOP_ALL_CLOCKS_O(stop_all), .INTERNAL_GEN_ENABLE_O(int_en),
    .EXTERNAL_GEN_ENABLE_O(ext_en), .INTERNAL_OSC_CLOCK_O(int_clk), .EXTERNAL_CLOCK_O(ext_clk),
    .BASE_CLOCK_O(base), .OSC_CTRL_WORD_O(word), .FILTER_STABLE_FLAG_O(stable), .IRQ_O(irq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Free-running oscillator stand-in, two clock cycles a period
  always @(posedge clk) if (osc_run) osc <= ~osc;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic cmp(input icgl_band_t b);
    @(posedge clk);
    done <= 1'b1;
    band <= b;
    @(posedge clk);
    done <= 1'b0;
    band <= 3'h6;
    #1;
  endtask
  task automatic t_reset;
    apb(1'b0, `ICGL_OFF_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h1, rd)
    apb(1'b0, `ICGL_OFF_MULT, 32'h0);
    `CHK("mult reset", 32'h1, rd)
    apb(1'b0, `ICGL_OFF_WORD, 32'h0);
    `CHK("word reset", 32'h04000400, rd)
    `CHK("word out", 12'h400, word)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'b0, `ICGL_OFF_ICLR, 32'h0);
    `CHK("clear reads", 32'h0, rd)
    $display("test reset done");
  endtask
  // Every on-bit and stop combination, with both raw clocks held high
  task automatic t_enable;
    logic [2:0] i;
    osc <= 1'b1;
    ext <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      i = k[2:0];
      apb(1'b1, `ICGL_OFF_CTRL, {30'h0, i[1:0]});
      stop <= i[2];
      tick(3);
      `CHK("stop all", i[2], stop_all)
      `CHK("int enable", i[0] & ~i[2], int_en)
      `CHK("ext enable", i[1] & ~i[2], ext_en)
      `CHK("int clock", i[0] & ~i[2], int_clk)
      `CHK("base clock", i[0] & ~i[2], base)
      `CHK("ext clock", i[1] & ~i[2], ext_clk)
      apb(1'b0, `ICGL_OFF_STAT, 32'h0);
      `CHK("status en", {i[2], i[1] & ~i[2], i[0] & ~i[2]}, {rd[3], rd[1:0]})
    end
    stop <= 1'b0;
    ext <= 1'b0;
    apb(1'b1, `ICGL_OFF_CTRL, 32'h1);
    $display("test enable done");
  endtask
  task automatic t_divider;
    int per, rises, w;
    logic p;
    apb(1'b1, `ICGL_OFF_MULT, 32'h4);
    osc_run = 1'b1;
    tick(20);
    w = 0;
    p = base;
    tick(1);
    while (!(base === 1'b1 && p === 1'b0) && w < 100) begin
      p = base;
      w++;
      tick(1);
    end
    per = 0;
    rises = 0;
    p = base;
    do begin
      if (osc === 1'b1 && int_clk === 1'b0) rises++;
      p = base;
      tick(1);
      per++;
    end while (!(base === 1'b1 && p === 1'b0) && per < 100);
    `CHK("base period", 8, per)
    `CHK("osc per base", 4, rises)
    for (int n = 0; n < 2; n++) begin
      apb(1'b1, `ICGL_OFF_MULT, n);
      tick(2);
      repeat (6) begin
        tick(1);
        `CHK("bypass", int_clk, base)
      end
    end
    osc_run = 1'b0;
    $display("test divider done");
  endtask
  icgl_band_t bands[8] = '{`ICGL_BAND_HI32, `ICGL_BAND_LO32, `ICGL_BAND_LO8, `ICGL_BAND_HI8,
    `ICGL_BAND_LO1, `ICGL_BAND_HI1, 3'h6, `ICGL_BAND_LO32};
  icgl_word_t exps[8] = '{12'h51f, 12'h4ff, 12'h4f7, 12'h4ff, 12'h4fe, 12'h4ff, 12'h4ff, 12'h4df};
  logic stabs[8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  task automatic t_filter;
    logic [31:0] c0;
    apb(1'b1, `ICGL_OFF_ICLR, 32'h7);
    apb(1'b0, `ICGL_OFF_CNT, 32'h0);
    c0 = rd;
    apb(1'b1, `ICGL_OFF_WORD, 32'h4ff);
    `CHK("preload", 12'h4ff, word)
    for (int k = 0; k < 8; k++) begin
      cmp(bands[k]);
      `CHK("word step", exps[k], word)
      `CHK("stable", stabs[k], stable)
      if (k == 5) begin
        apb(1'b0, `ICGL_OFF_ISTAT, 32'h0);
        `CHK("stable rose", 1'b1, rd[`ICGL_IRQ_LOCK])
      end
    end
    tick(6);
    `CHK("word held", 12'h4df, word)
    apb(1'b0, `ICGL_OFF_CNT, 32'h0);
    `CHK("one per compare", c0 + 32'd8, rd)
    apb(1'b1, `ICGL_OFF_CTRL, 32'h0);
    cmp(`ICGL_BAND_HI32);
    `CHK("ignored off", 12'h4df, word)
    apb(1'b1, `ICGL_OFF_CTRL, 32'h1);
    $display("test filter done");
  endtask
  task automatic t_limit;
    apb(1'b1, `ICGL_OFF_ICLR, 32'h7);
    apb(1'b1, `ICGL_OFF_IEN, 32'h4);
    `CHK("irq idle", 1'b0, irq)
    apb(1'b1, `ICGL_OFF_WORD, 32'h9f0);
    cmp(`ICGL_BAND_HI32);
    `CHK("eff clamp", 12'h910, word)
    apb(1'b0, `ICGL_OFF_WORD, 32'h0);
    `CHK("raw over", 32'h09100a10, rd)
    `CHK("irq set", 1'b1, irq)
    apb(1'b1, `ICGL_OFF_IEN, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b0, `ICGL_OFF_ISTAT, 32'h0);
    `CHK("status kept", 1'b1, rd[`ICGL_IRQ_LIMIT])
    apb(1'b1, `ICGL_OFF_IEN, 32'h4);
    `CHK("irq again", 1'b1, irq)
    cmp(`ICGL_BAND_LO32);
    `CHK("recover", 12'h9f0, word)
    apb(1'b1, `ICGL_OFF_ICLR, 32'h4);
    `CHK("irq cleared", 1'b0, irq)
    apb(1'b1, `ICGL_OFF_WORD, 32'h010);
    cmp(`ICGL_BAND_LO32);
    `CHK("under clamp", 12'h9f0, word)
    apb(1'b0, `ICGL_OFF_WORD, 32'h0);
    `CHK("raw under", 32'h09f00ff0, rd)
    apb(1'b1, 8'h20, 32'h0);
    `CHK("bad write err", 1'b1, er)
    $display("test limit done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    err_count = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    {psel, penable, pwrite, stop, osc, ext, done, osc_run} = 8'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    band = 3'h6;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_enable();
    t_divider();
    t_filter();
    t_limit();
    tally_and_finish();
  end
endmodule
